// [core/sacp_convert_start_port.sv]
`default_nettype none
module sacp_convert_start_port
  import sacp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic convert_start_i,
  input wire logic [15:0] positive_input_i,
  input wire logic [15:0] negative_input_i,
  output logic sdo_o,
  output logic sdo_oe_n_o,
  output logic busy_o,
  output logic nap_o,
  output logic sleep_o
);
  sacp_pwr_if pwr ();
  sacp_state_t state_reg;
  sacp_state_t state_next;
  logic sck_prev_reg;
  logic convert_start_prev_reg;
  logic [4:0] edge_cnt_reg;
  logic [4:0] edge_cnt_next;
  logic [4:0] edge_cnt_inc;
  logic [13:0] held_reg;
  logic [13:0] held_next;
  logic [13:0] result_reg;
  logic [13:0] result_next;
  logic [13:0] shift_reg;
  logic [13:0] shift_next;
  logic sdo_next;
  logic sdo_oe_n_next;
  logic busy_next;
  logic convert_start_go;
  logic word_step;
  logic word_last;
  logic data_step;

  // ----------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      convert_start_prev_reg <= 1'b0;
    end else begin
      convert_start_prev_reg <= convert_start_i;
    end
  end

  assign pwr.sck_rise = rise(sck_i, sck_prev_reg);
  assign pwr.convert_start_rise = rise(convert_start_i, convert_start_prev_reg);

  sacp_pwr_ctl u_pwr (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pwr(pwr)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // A strobe while asleep changes nothing, as the count already rests at SLEEP_COUNT; the host must wake us first.
  assign convert_start_go = pwr.convert_start_rise && (state_reg == SACP_IDLE) && !pwr.sleep;
  assign edge_cnt_inc = edge_cnt_reg + 5'h01;
  assign word_step = (state_reg == SACP_CONVERT_START) && pwr.sck_rise;
  assign word_last = word_step && (edge_cnt_inc == EDGES_PER_WORD);
  assign data_step = word_step && (edge_cnt_inc <= LAST_DATA_EDGE);

  // ----------------------------------------------------------------
  // Conversion sequence
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SACP_IDLE: begin
        if (convert_start_go) begin
          state_next = SACP_CONVERT_START;
        end
      end
      SACP_CONVERT_START: begin
        if (word_last) begin
          state_next = SACP_IDLE;
        end
      end
      default: begin
        state_next = SACP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= SACP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // The count stops at sixteen and waits there for the next strobe.
  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    if (convert_start_go) begin
      edge_cnt_next = 5'h00;
    end else if (word_step) begin
      edge_cnt_next = edge_cnt_inc;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      edge_cnt_reg <= 5'h00;
    end else begin
      edge_cnt_reg <= edge_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Sample and result
  // ----------------------------------------------------------------
  // The held value becomes the next word only once its conversion ends.
  always_comb begin
    held_next = held_reg;
    if (convert_start_go) begin
      held_next = clamp_diff(positive_input_i, negative_input_i);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      held_reg <= RESULT_RESET;
    end else begin
      held_reg <= held_next;
    end
  end

  always_comb begin
    result_next = result_reg;
    if (word_last) begin
      result_next = held_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      result_reg <= RESULT_RESET;
    end else begin
      result_reg <= result_next;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  always_comb begin
    shift_next = shift_reg;
    if (convert_start_go) begin
      shift_next = result_reg;
    end else if (data_step) begin
      shift_next = {shift_reg[12:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      shift_reg <= RESULT_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // Rises fifteen and sixteen leave the pin released, so the host sees a clean gap.
  always_comb begin
    sdo_next = sdo_o;
    sdo_oe_n_next = sdo_oe_n_o;
    if (data_step) begin
      sdo_next = shift_reg[RES_BITS-1];
      sdo_oe_n_next = 1'b0;
    end else if (word_step) begin
      sdo_next = 1'b0;
      sdo_oe_n_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sdo_o <= 1'b0;
    end else begin
      sdo_o <= sdo_next;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sdo_oe_n_o <= 1'b1;
    end else begin
      sdo_oe_n_o <= sdo_oe_n_next;
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  assign busy_next = convert_start_go || ((state_reg == SACP_CONVERT_START) && !word_last);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= busy_next;
    end
  end

  // The power flags come straight from the controller's flops, with no extra stage.
  assign nap_o = pwr.nap;
  assign sleep_o = pwr.sleep;
endmodule // sacp_convert_start_port
`default_nettype wire

// [core/sacp_pkg.sv]
`default_nettype none
package sacp_pkg;
  localparam int RES_BITS = 14;
  localparam int IN_BITS = 16;
  localparam logic [13:0] FULL_SCALE_CODE = 14'h3fff;
  localparam logic [13:0] RESULT_RESET = 14'h0000;
  localparam logic [4:0] EDGES_PER_WORD = 5'h10;
  localparam logic [4:0] LAST_DATA_EDGE = 5'h0e;
  localparam logic [2:0] NAP_COUNT = 3'h2;
  localparam logic [2:0] SLEEP_COUNT = 3'h4;

  typedef enum logic [0:0] {
    SACP_IDLE = 1'b0,
    SACP_CONVERT_START = 1'b1
  } sacp_state_t;

  function automatic logic rise(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction

  // Input levels are in code steps; full scale is the top code.
  function automatic logic [13:0] clamp_diff(input logic [15:0] p, input logic [15:0] n);
    logic [15:0] d;
    d = p - n;
    if (n > p) begin
      return 14'h0000;
    end else if (d > {2'b00, FULL_SCALE_CODE}) begin
      return FULL_SCALE_CODE;
    end
    return d[13:0];
  endfunction
endpackage
`default_nettype wire

// [core/sacp_pwr_if.sv]
`default_nettype none
interface sacp_pwr_if;
  logic convert_start_rise;
  logic sck_rise;
  logic nap;
  logic sleep;
  modport ctl (input convert_start_rise, input sck_rise, output nap, output sleep);
  modport core (output convert_start_rise, output sck_rise, input nap, input sleep);
endinterface
`default_nettype wire

// [core/sacp_pwr_ctl.sv]
`default_nettype none
module sacp_pwr_ctl
  import sacp_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  sacp_pwr_if.ctl pwr
);
  logic [2:0] start_cnt_reg;

  // ----------------------------------------------------------------
  // Strobe counter
  // ----------------------------------------------------------------
  // The counter saturates so a long string of strobes stays asleep.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      start_cnt_reg <= 3'h0;
    end else if (pwr.sck_rise) begin
      start_cnt_reg <= 3'h0;
    end else if (pwr.convert_start_rise && start_cnt_reg != SLEEP_COUNT) begin
      start_cnt_reg <= start_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pwr.nap <= 1'b0;
      pwr.sleep <= 1'b0;
    end else if (pwr.sck_rise) begin
      pwr.nap <= 1'b0;
      pwr.sleep <= 1'b0;
    end else if (pwr.convert_start_rise) begin
      pwr.nap <= (start_cnt_reg + 3'h1 >= NAP_COUNT) &&
                 (start_cnt_reg + 3'h1 < SLEEP_COUNT);
      pwr.sleep <= (start_cnt_reg + 3'h1 >= SLEEP_COUNT);
    end
  end
endmodule // sacp_pwr_ctl
`default_nettype wire

// [tb/sacp_convert_start_port_monitor.sv]
`default_nettype none
module sacp_convert_start_port_monitor (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sck_i,
  input wire logic convert_start_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_n_o,
  input wire logic busy_o,
  input wire logic nap_o,
  input wire logic sleep_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cs_reg, sk_reg, cr, sr;
  logic [4:0] n_reg;
  assign cr = convert_start_i & ~cs_reg;
  assign sr = sck_i & ~sk_reg;
  // The edge count restarts whenever busy drops, so a stuck count shows at once.
  always_ff @(posedge ref_clk_i) begin
    cs_reg <= rst_i ? 1'b0 : convert_start_i;
    sk_reg <= rst_i ? 1'b0 : sck_i;
    n_reg <= (rst_i || !busy_o) ? 5'h0 : n_reg + {4'h0, sr};
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hiz;
    sdo_oe_n_o && !sdo_o;
  endsequence
  a_convert_start_sets_busy: assert property (cr && !busy_o && !sleep_o |=> busy_o)
    else $error("conversion not started");
  a_sck_wakes: assert property (sr |=> !nap_o && !sleep_o)
    else $error("power state kept after shift edge");
  a_power_static: assert property (!cr && !sr |=> $stable(nap_o) && $stable(sleep_o))
    else $error("power state moved without cause");
  a_sdo_stable: assert property (!sr |=> $stable(sdo_o) && $stable(sdo_oe_n_o))
    else $error("output moved off a shift edge");
  a_drive_busy: assert property (!sdo_oe_n_o |-> busy_o && !nap_o)
    else $error("output driven while idle");
  a_busy_holds: assert property (busy_o && !(sr && n_reg == 5'hf) |=> busy_o)
    else $error("busy dropped early");
  a_word_ends: assert property (busy_o && sr && n_reg == 5'hf |=> !busy_o)
    else $error("busy kept after last edge");
  a_data_window: assert property (busy_o && sr && n_reg < 5'he |=> !sdo_oe_n_o)
    else $error("data bit not driven");
  a_hiz_after: assert property (busy_o && sr && n_reg == 5'he |=> s_hiz)
    else $error("output not released after last bit");
endmodule // sacp_convert_start_port_monitor
bind sacp_convert_start_port sacp_convert_start_port_monitor i_mon (.ref_clk_i, .rst_i, .sck_i, .convert_start_i,
  .sdo_o, .sdo_oe_n_o, .busy_o, .nap_o, .sleep_o);
`default_nettype wire

// [tb/sacp_host_model.sv]
`default_nettype none
module sacp_host_model (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic sdo_i,
  input wire logic sdo_oe_n_i,
  output logic sck_o,
  output logic [13:0] word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_reg = 2'h0;
  // The shift clock stands still low between frames.
  assign sck_o = ph_reg[1];
  // Bits are taken just before the next rise, where each has had time to settle.
  always_ff @(posedge ref_clk_i) begin
    if (run_i) begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h1 && !sdo_oe_n_i) begin
        word_o <= {word_o[12:0], sdo_i};
      end
    end
  end
endmodule // sacp_host_model
`default_nettype wire

// [tb/sacp_convert_start_port_tb_top.sv]
`default_nettype none
module sacp_convert_start_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, cs = 1'b0, run = 1'b0;
  logic [15:0] p = 16'h0, n = 16'h0;
  logic sck, sdo, oe_n, busy, nap, slp;
  logic [13:0] word;
  int err_count = 0, checked = 0, cyc = 0;
  int q[$];
  always #2 ref_clk_i = ~ref_clk_i;
  sacp_convert_start_port i_dut (.ref_clk_i, .rst_i, .sck_i(sck), .convert_start_i(cs),
    .positive_input_i(p), .negative_input_i(n), .sdo_o(sdo), .sdo_oe_n_o(oe_n),
    .busy_o(busy), .nap_o(nap), .sleep_o(slp));
  sacp_host_model i_host (.ref_clk_i, .run_i(run), .sdo_i(sdo), .sdo_oe_n_i(oe_n),
    .sck_o(sck), .word_o(word));
  task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  function automatic int clampm(input int a, input int b);
    return (a < b) ? 0 : ((a - b > 16383) ? 16383 : a - b);
  endfunction
  task automatic strobe(input int pv, input int nv);
    @(posedge ref_clk_i);
    p <= pv[15:0];
    n <= nv[15:0];
    cs <= 1'b1;
    @(posedge ref_clk_i);
    cs <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Sixty-four cycles give exactly sixteen shift rises and leave the clock low.
  task automatic frame;
    run <= 1'b1;
    repeat (64) @(posedge ref_clk_i);
    run <= 1'b0;
    @(posedge ref_clk_i);
    chk("word", word, 14'(q.pop_front()));
    chk("done", {busy, oe_n}, 2'h1);
  endtask
  initial begin
    int pv, nv;
    static int ep[4] = '{0, 5, 20000, 16383};
    static int en[4] = '{0, 100, 1, 0};
    void'($urandom(32'h61fc));
    q.push_back(0);
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    chk("idle", {busy, nap, slp, oe_n}, 4'h1);
    for (int i = 0; i < 12; i++) begin
      pv = (i < 4) ? ep[i] : $urandom_range(20000);
      nv = (i < 4) ? en[i] : $urandom_range(20000);
      strobe(pv, nv);
      q.push_back(clampm(pv, nv));
      chk("busy", busy, 1'b1);
      frame();
    end
    $display("test conversions done");
    for (int k = 1; k < 6; k++) begin
      strobe(1000 * k, 0);
      if (k == 1) q.push_back(1000);
      chk("power", {nap, slp}, (k >= 4) ? 2'h1 : ((k >= 2) ? 2'h2 : 2'h0));
    end
    frame();
    chk("wake", {nap, slp}, 2'h0);
    strobe(0, 0);
    q.push_back(0);
    frame();
    $display("test power done");
    tally_and_finish();
  end
endmodule // sacp_convert_start_port_tb_top
`default_nettype wire
